// *** hw/ctm_cfg_if.sv ***
// Interface carrying decoded control fields from the top to the pin stage
`timescale 1ns/10ps
interface ctm_cfg_if;
  logic [1:0] mode;        // Operating mode
  logic [1:0] action;      // pin_action field
  logic       level;       // output_level_select
  logic       invert;      // output_invert
  logic       run_rise;    // timer_run went low to high
  logic       match_a;     // Comparator A match pulse
  logic       duty_on;     // PWM duty phase
  logic       pin;         // Resulting pin level
  logic       pin_oe;      // Pin is driven

  modport ctl (output mode, action, level, invert, run_rise, match_a, duty_on,
               input pin, pin_oe);
  modport pin_stage (input mode, action, level, invert, run_rise, match_a, duty_on,
                     output pin, pin_oe);
endinterface : ctm_cfg_if

// *** hw/ctm_pin_stage.sv ***
// Timer output pin stage: compare match actions, PWM shaping and inversion
`timescale 1ns/10ps
module ctm_pin_stage
(
  input  wire logic   i_clock,   // System clock
  input  wire logic   i_rst_n,   // Async reset, active low
  ctm_cfg_if.pin_stage cfg       // Control fields and pin result
);

  // ----------------------------------------------------------------
  // Compare mode latch
  // ----------------------------------------------------------------
  logic cmp_q;
  logic cmp_d;
  logic pwm_raw;
  logic pre_inv;
  logic is_pwm;
  logic is_cmp;

  assign is_pwm = (cfg.mode == ctm_pkg::MODE_PWM);
  assign is_cmp = (cfg.mode == ctm_pkg::MODE_CMP);

  // Only a match A moves the level; run rising edge restores the initial level
  always_comb
  begin
    cmp_d = cmp_q;
    if (cfg.run_rise)
      cmp_d = cfg.level;
    else if (cfg.match_a)
    begin
      unique case (cfg.action)
        ctm_pkg::ACT_NONE: cmp_d = cmp_q;
        ctm_pkg::ACT_LOW:  cmp_d = 1'b0;
        ctm_pkg::ACT_HIGH: cmp_d = 1'b1;
        ctm_pkg::ACT_TOG:  cmp_d = ~cmp_q;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cmp_q <= 1'b0;
    else
      cmp_q <= cmp_d;
  end

  // ----------------------------------------------------------------
  // PWM shaping: 00 inactive, 01 active, 10 waveform, 11 undefined as inactive
  // ----------------------------------------------------------------
  assign pwm_raw = (cfg.action == ctm_pkg::ACT_HIGH) ?
                   (cfg.duty_on ? cfg.level : ~cfg.level) :
                   (cfg.action == ctm_pkg::ACT_LOW) ? cfg.level : ~cfg.level;

  assign pre_inv = is_pwm ? pwm_raw : cmp_q;
  assign cfg.pin    = pre_inv ^ cfg.invert;
  // Mode 01 and timer/counter mode leave the pin undriven
  assign cfg.pin_oe = is_pwm | is_cmp;

endmodule : ctm_pin_stage

// *** hw/ctm_pkg.sv ***
// Package with register map, field positions and encodings for the compact timer
package ctm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00; // timer_mode_output_control
  localparam logic [7:0] OFS_RUN      = 8'h04; // timer_run
  localparam logic [7:0] OFS_CMP_A    = 8'h08; // compare_a_value
  localparam logic [7:0] OFS_CMP_P    = 8'h0C; // compare_p_value
  localparam logic [7:0] OFS_STATUS   = 8'h10; // sticky events, read only
  localparam logic [7:0] OFS_INT_EN   = 8'h14; // interrupt enable
  localparam logic [7:0] OFS_INT_CLR  = 8'h18; // write one to clear
  localparam logic [7:0] OFS_COUNT    = 8'h1C; // counter and pin state

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int MODE_HI   = 7;
  localparam int MODE_LO   = 6;
  localparam int ACT_HI    = 5;
  localparam int ACT_LO    = 4;
  localparam int LEVEL_BIT = 3;
  localparam int INV_BIT   = 2;
  localparam int SWAP_BIT  = 1;
  localparam int CLR_BIT   = 0;

  // ----------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int         CNT_W      = 10;
  localparam int         CMP_P_W    = 3;
  localparam int         EVT_W      = 2;  // bit0 match A, bit1 match P
  localparam int         EVT_A      = 0;
  localparam int         EVT_P      = 1;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CMP   = 2'h0;
  localparam logic [1:0] MODE_UNDEF = 2'h1;
  localparam logic [1:0] MODE_PWM   = 2'h2;
  localparam logic [1:0] MODE_TC    = 2'h3;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOG    = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ctm_pkg

// *** hw/ctm_top.sv ***
// Compact timer with mode/output control register and AXI4-Lite slave
// Functional notes
// - Mode codes 00 compare, 10 PWM, 11 timer
// - Compare mode: level bit sets initial pin
// - PWM mode: level bit sets active level
// - Invert bit inverts pin; unused in timer
// - Swap bit exchanges period and duty registers
// - Clear source: 0 match P, 1 match A
// - Clear source low: P match or overflow
// - Overflow clear only when compare P zero
// - PWM ignores clear source; swap picks period
// - Match A drives pin low, high, toggle
// - Run rising edge restores initial pin level
// - Only match A changes pin in compare mode
// - PWM generation runs with action 10
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module ctm_top #(
  parameter int CNT_W   = ctm_pkg::CNT_W,   // Counter width
  parameter int CMP_P_W = ctm_pkg::CMP_P_W  // Compare P width (top counter bits)
)
(
  input  wire logic        i_clock,          // 10 MHz system clock
  input  wire logic        i_rst_n,          // Async reset, active low
  input  wire logic        i_awvalid,        // Write address valid
  output logic             o_awready,        // Write address ready
  input  wire logic [7:0]  i_awaddr,         // Write address
  input  wire logic        i_wvalid,         // Write data valid
  output logic             o_wready,         // Write data ready
  input  wire logic [31:0] i_wdata,          // Write data
  input  wire logic [3:0]  i_wstrb,          // Write byte strobes
  output logic             o_bvalid,         // Write response valid
  input  wire logic        i_bready,         // Write response ready
  output logic [1:0]       o_bresp,          // Write response
  input  wire logic        i_arvalid,        // Read address valid
  output logic             o_arready,        // Read address ready
  input  wire logic [7:0]  i_araddr,         // Read address
  output logic             o_rvalid,         // Read data valid
  input  wire logic        i_rready,         // Read data ready
  output logic [31:0]      o_rdata,          // Read data
  output logic [1:0]       o_rresp,          // Read response
  output logic             o_timer_output_pin_a,    // Timer output pin
  output logic             o_timer_output_pin_a_oe, // Pin driven
  output logic             o_timer_output_pin_b,    // Complementary pin
  output logic             o_timer_output_pin_b_oe, // Pin driven
  output logic             o_irq             // Level interrupt
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]          ctrl_q;
  logic                run_q;
  logic                run_prev_q;
  logic [CNT_W-1:0]    cmp_a_q;
  logic [CMP_P_W-1:0]  cmp_p_q;
  logic [CNT_W-1:0]    count_q;
  logic [ctm_pkg::EVT_W-1:0] status_q;
  logic [ctm_pkg::EVT_W-1:0] int_en_q;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [1:0] mode   = ctrl_q[ctm_pkg::MODE_HI:ctm_pkg::MODE_LO];
  wire [1:0] action = ctrl_q[ctm_pkg::ACT_HI:ctm_pkg::ACT_LO];
  wire       swap   = ctrl_q[ctm_pkg::SWAP_BIT];
  wire       clr_a  = ctrl_q[ctm_pkg::CLR_BIT];
  wire       is_pwm = (mode == ctm_pkg::MODE_PWM);

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // Compare P holds only the top counter bits and matches when the lower bits are zero; a zero value means full range.
  // Matches look at the value the counter is about to reach, so a clear on a
  // match gives a period of exactly the compare value, not one count more.
  wire [CNT_W-1:0]   cnt_nx  = count_q + 1'b1;
  wire [CMP_P_W-1:0] cnt_top = cnt_nx[CNT_W-1 -: CMP_P_W];
  wire p_zero  = (cmp_p_q == '0);
  wire match_p = run_q && !p_zero && (cnt_top == cmp_p_q)
                 && (cnt_nx[CNT_W-CMP_P_W-1:0] == '0);
  wire match_a = run_q && (cnt_nx == cmp_a_q) && (cmp_a_q != '0);
  wire at_max  = (count_q == {CNT_W{1'b1}});
  wire overflow = run_q && at_max;

  // Clear source: PWM ignores the select bit and uses the period comparator
  wire clr_by_a = is_pwm ? swap : clr_a;
  // Overflow only clears when compare P is zero, else match P came first
  wire clr_p_path = match_p || (overflow && p_zero);
  wire clear_cnt  = clr_by_a ? match_a : clr_p_path;

  // PWM duty compare: duty value from whichever register is not the period
  wire [CNT_W-1:0] p_full = {cmp_p_q, {(CNT_W-CMP_P_W){1'b0}}};
  wire [CNT_W-1:0] duty_v = swap ? p_full : cmp_a_q;
  wire duty_full = swap ? p_zero : 1'b0;
  // Duty tracks the counter even when the pin is forced; the match flags do not depend on it
  wire duty_on = duty_full || (count_q < duty_v);

  // P flag suppressed when match A clears in compare/timer modes
  wire evt_p = match_p && (is_pwm || !clr_a);
  wire evt_a = match_a;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count_q <= '0;
    else if (!run_q || clear_cnt)
      count_q <= '0;
    else
      count_q <= count_q + 1'b1;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      run_prev_q <= 1'b0;
    else
      run_prev_q <= run_q;
  end

  // ----------------------------------------------------------------
  // Pin stage
  // ----------------------------------------------------------------
  ctm_cfg_if cfg ();
  assign cfg.mode     = mode;
  assign cfg.action   = action;
  assign cfg.level    = ctrl_q[ctm_pkg::LEVEL_BIT];
  assign cfg.invert   = ctrl_q[ctm_pkg::INV_BIT];
  assign cfg.run_rise = run_q && !run_prev_q;
  assign cfg.match_a  = match_a && (mode != ctm_pkg::MODE_PWM);
  assign cfg.duty_on  = duty_on;

  ctm_pin_stage u_pin (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .cfg     (cfg)
  );

  // Registered outputs keep the pins glitch free
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_timer_output_pin_a    <= 1'b0;
      o_timer_output_pin_a_oe <= 1'b0;
      o_timer_output_pin_b    <= 1'b0;
      o_timer_output_pin_b_oe <= 1'b0;
    end
    else
    begin
      o_timer_output_pin_a    <= cfg.pin;
      o_timer_output_pin_a_oe <= cfg.pin_oe;
      o_timer_output_pin_b    <= ~cfg.pin;
      o_timer_output_pin_b_oe <= cfg.pin_oe;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic       aw_held_q;
  logic       w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  wire aw_take = i_awvalid && o_awready;
  wire w_take  = i_wvalid && o_wready;
  wire [7:0]  wr_addr = aw_held_q ? aw_addr_q : i_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : i_wdata;
  wire [3:0]  wr_strb = w_held_q ? w_strb_q : i_wstrb;
  wire have_aw = aw_held_q || aw_take;
  wire have_w  = w_held_q || w_take;
  wire wr_go   = have_aw && have_w && !o_bvalid;
  wire wr_hit  = is_mapped(wr_addr);
  wire wr_en   = wr_go && wr_hit && wr_strb[0];
  wire [7:0] wb = wr_data[7:0];

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= ctm_pkg::OFS_COUNT);
  endfunction : is_mapped

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= ctm_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
        o_wready <= 1'b0;
      end
      aw_held_q <= wr_go ? 1'b0 : have_aw;
      w_held_q  <= wr_go ? 1'b0 : have_w;
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? ctm_pkg::RESP_OKAY : ctm_pkg::RESP_SLVERR;
      end
      else if (o_bvalid && i_bready)
      begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  wire [CNT_W-1:0] wr_cmp_a = wr_data[CNT_W-1:0];
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_q   <= ctm_pkg::CTRL_RESET;
      run_q    <= 1'b0;
      cmp_a_q  <= '0;
      cmp_p_q  <= '0;
      int_en_q <= '0;
    end
    else if (wr_en)
    begin
      if (wr_addr == ctm_pkg::OFS_CTRL)
        ctrl_q <= wb;
      if (wr_addr == ctm_pkg::OFS_RUN)
        run_q <= wb[0];
      if (wr_addr == ctm_pkg::OFS_CMP_A && wr_strb[1])
        cmp_a_q <= wr_cmp_a;
      if (wr_addr == ctm_pkg::OFS_CMP_P)
        cmp_p_q <= wb[CMP_P_W-1:0];
      if (wr_addr == ctm_pkg::OFS_INT_EN)
        int_en_q <= wb[ctm_pkg::EVT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sticky status and interrupt; a new event wins over a clear
  // ----------------------------------------------------------------
  wire [ctm_pkg::EVT_W-1:0] evt = {evt_p, evt_a};
  wire [ctm_pkg::EVT_W-1:0] clr_mask =
    (wr_en && wr_addr == ctm_pkg::OFS_INT_CLR) ? wb[ctm_pkg::EVT_W-1:0] : '0;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      status_q <= '0;
      o_irq    <= 1'b0;
    end
    else
    begin
      status_q <= (status_q & ~clr_mask) | evt;
      o_irq    <= |(((status_q & ~clr_mask) | evt) & int_en_q);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (i_araddr)
      ctm_pkg::OFS_CTRL:   rd_mux[7:0] = ctrl_q;
      ctm_pkg::OFS_RUN:    rd_mux[0] = run_q;
      ctm_pkg::OFS_CMP_A:  rd_mux[CNT_W-1:0] = cmp_a_q;
      ctm_pkg::OFS_CMP_P:  rd_mux[CMP_P_W-1:0] = cmp_p_q;
      ctm_pkg::OFS_STATUS: rd_mux[ctm_pkg::EVT_W-1:0] = status_q;
      ctm_pkg::OFS_INT_EN: rd_mux[ctm_pkg::EVT_W-1:0] = int_en_q;
      ctm_pkg::OFS_COUNT:  rd_mux = {15'h0000, o_timer_output_pin_a, 6'h00, count_q};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= ctm_pkg::RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_mux;
      o_rresp   <= is_mapped(i_araddr) ? ctm_pkg::RESP_OKAY : ctm_pkg::RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  pin_undriven_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (mode == ctm_pkg::MODE_TC) |=> !o_timer_output_pin_a_oe)
    else $error("pin driven in timer mode");

  run_restore_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (cfg.run_rise && mode == ctm_pkg::MODE_CMP && $stable(ctrl_q))
    |=> ##1 (o_timer_output_pin_a == ($past(ctrl_q[3], 2) ^ $past(ctrl_q[2], 2))))
    else $error("run edge did not restore level");

  p_no_pin_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (mode == ctm_pkg::MODE_CMP && !match_a && !cfg.run_rise && $stable(ctrl_q))
    |=> (u_pin.cmp_q == $past(u_pin.cmp_q)))
    else $error("pin moved without match A");

  toggle_act_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (cfg.match_a && !cfg.run_rise && action == ctm_pkg::ACT_TOG)
    |=> (u_pin.cmp_q != $past(u_pin.cmp_q)))
    else $error("toggle action missed");

  pwm_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (is_pwm && run_q && match_a && !swap && !match_p && !overflow)
    |=> (count_q != '0))
    else $error("PWM cleared by A with swap low");

  clear_a_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!is_pwm && clr_a && run_q && match_a) |=> (count_q == '0))
    else $error("match A did not clear");

  overflow_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!is_pwm && !clr_a && run_q && at_max && !p_zero && !match_a) |=> 0)
    else $error("counter reached max with P nonzero");

  p_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!is_pwm && !clr_a && match_p) |=> (count_q == '0))
    else $error("match P did not clear");

  invert_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (is_pwm && action == ctm_pkg::ACT_LOW && $stable(ctrl_q))
    |=> (o_timer_output_pin_a == ($past(ctrl_q[3]) ^ $past(ctrl_q[2]))))
    else $error("PWM forced active level wrong");

endmodule : ctm_top

// *** verification/ctm_load_model.sv ***
// External load model that watches the timer output pins
`timescale 1ns/10ps
module ctm_load_model
(
  input  wire logic i_clock,    // System clock
  input  wire logic i_pin_a,    // Timer output pin
  input  wire logic i_pin_b,    // Complementary pin
  input  wire logic i_oe,       // Pins driven
  input  wire logic i_clear,    // Restart the high-time count
  output int        o_high_cnt, // Cycles seen high while driven
  output int        o_bad_cnt   // Cycles where pin b was not the complement
);
  // An undriven pin reads as low through the load's pull-down, so only driven highs count
  always @(posedge i_clock)
  begin
    if (i_clear)
    begin
      o_high_cnt <= 0;
    end
    else if (i_oe && i_pin_a)
    begin
      o_high_cnt <= o_high_cnt + 1;
    end
    if (i_oe && (i_pin_b !== ~i_pin_a))
    begin
      o_bad_cnt <= o_bad_cnt + 1;
    end
  end
endmodule : ctm_load_model

// *** verification/tb_compact_timer_mode_output_control.sv ***
// Self-checking bench for the compact timer mode and output control
`timescale 1ns/10ps
module tb_compact_timer_mode_output_control;
  logic        i_clock, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, load_clr;
  logic        pin_a, pin_a_oe, pin_b, pin_b_oe;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd_q;
  logic [1:0]  o_bresp, o_rresp;
  int          error_cnt, compares, high_cnt, bad_cnt;

  ctm_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .i_wdata(i_wdata), .i_wstrb(4'hF), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_timer_output_pin_a(pin_a), .o_timer_output_pin_a_oe(pin_a_oe),
    .o_timer_output_pin_b(pin_b), .o_timer_output_pin_b_oe(pin_b_oe), .o_irq(o_irq));

  ctm_load_model load (.i_clock(i_clock), .i_pin_a(pin_a), .i_pin_b(pin_b), .i_oe(pin_a_oe),
    .i_clear(load_clr), .o_high_cnt(high_cnt), .o_bad_cnt(bad_cnt));

  // Clock at 10 MHz
  initial
  begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One bus transfer; requests are held until the ready seen at the edge before release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er, output logic [31:0] q);
    logic aw, w, ar, done;
    logic [1:0] r;
    int n;
    aw = wr;
    w = wr;
    ar = !wr;
    done = 1'b0;
    n = 0;
    @(posedge i_clock);
    i_awvalid <= wr;
    i_wvalid <= wr;
    i_arvalid <= !wr;
    i_awaddr <= a;
    i_araddr <= a;
    i_wdata <= d;
    i_bready <= wr;
    i_rready <= !wr;
    while (!done && n < 50)
    begin
      @(negedge i_clock);
      aw = aw && !o_awready;
      w = w && !o_wready;
      ar = ar && !o_arready;
      done = wr ? o_bvalid : o_rvalid;
      r = wr ? o_bresp : o_rresp;
      q = o_rdata;
      @(posedge i_clock);
      i_awvalid <= aw;
      i_wvalid <= w;
      i_arvalid <= ar;
      n++;
    end
    i_bready <= 1'b0;
    i_rready <= 1'b0;
    chk({31'h0, done}, 32'h1, "bus answer");
    chk({30'h0, r}, {30'h0, er}, "bus response");
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, ctm_pkg::RESP_OKAY, rd_q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0, ctm_pkg::RESP_OKAY, rd_q);
    chk(rd_q, exp, what);
  endtask : rd_chk

  // Poll the status register; polling bounds the wait, no latency is assumed
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    rd_q = 32'h0;
    while (rd_q[b] !== 1'b1 && n < 600)
    begin
      xfer(1'b0, ctm_pkg::OFS_STATUS, 32'h0, ctm_pkg::RESP_OKAY, rd_q);
      n++;
    end
    chk({31'h0, rd_q[b]}, 32'h1, "event flag");
  endtask : wait_flag

  // Configuration is only touched while the timer is stopped
  task automatic start(input logic [7:0] c, input logic [9:0] a, input logic [2:0] p);
    wr(ctm_pkg::OFS_RUN, 32'h0);
    wr(ctm_pkg::OFS_CTRL, {24'h0, c});
    wr(ctm_pkg::OFS_CMP_A, {22'h0, a});
    wr(ctm_pkg::OFS_CMP_P, {29'h0, p});
    wr(ctm_pkg::OFS_INT_CLR, 32'h3);
    wr(ctm_pkg::OFS_RUN, 32'h1);
  endtask : start

  task automatic t_regs();
    rd_chk(ctm_pkg::OFS_CTRL, 32'h0, "control reset");
    rd_chk(ctm_pkg::OFS_STATUS, 32'h0, "status reset");
    wr(ctm_pkg::OFS_CTRL, 32'h3F);
    rd_chk(ctm_pkg::OFS_CTRL, 32'h3F, "control readback");
    rd_chk(ctm_pkg::OFS_INT_CLR, 32'h0, "clear reads zero");
    xfer(1'b0, 8'h20, 32'h0, ctm_pkg::RESP_SLVERR, rd_q);
    xfer(1'b1, 8'h20, 32'h1, ctm_pkg::RESP_SLVERR, rd_q);
  endtask : t_regs

  // Every pin action, level and inversion in compare mode; P match later clears the count
  task automatic t_compare();
    logic e;
    for (int i = 0; i < 16; i++)
    begin
      start({2'b00, i[1:0], i[2], i[3], 2'b00}, 10'd100, 3'd1);
      repeat (4) @(negedge i_clock);
      e = i[2] ^ i[3];
      chk({31'h0, pin_a}, {31'h0, e}, "initial level");
      chk({31'h0, pin_a_oe}, 32'h1, "compare mode drives");
      chk({31'h0, pin_b_oe}, 32'h1, "pin b driven");
      wait_flag(ctm_pkg::EVT_A);
      repeat (4) @(negedge i_clock);
      case (i[1:0])
        2'd1: e = i[3];
        2'd2: e = !i[3];
        2'd3: e = !e;
        default: e = e;
      endcase
      chk({31'h0, pin_a}, {31'h0, e}, "match A action");
      wait_flag(ctm_pkg::EVT_P);
      chk({31'h0, pin_a}, {31'h0, e}, "P match keeps pin");
      xfer(1'b0, ctm_pkg::OFS_COUNT, 32'h0, ctm_pkg::RESP_OKAY, rd_q);
      chk({29'h0, rd_q[9:7]}, 32'h0, "count cleared by P");
    end
  endtask : t_compare

  task automatic t_clear_src();
    start(8'h01, 10'd50, 3'd1);
    repeat (300) @(negedge i_clock);
    rd_chk(ctm_pkg::OFS_STATUS, 32'h1, "A clears, no P flag");
    xfer(1'b0, ctm_pkg::OFS_COUNT, 32'h0, ctm_pkg::RESP_OKAY, rd_q);
    chk({31'h0, rd_q[9:0] <= 10'd50}, 32'h1, "count bounded by A");
    start(8'h00, 10'd1000, 3'd0);
    wait_flag(ctm_pkg::EVT_A);
    chk(rd_q, 32'h1, "overflow run, no P flag");
  endtask : t_clear_src

  // Undefined and timer modes leave the pin undriven while the counter still runs
  task automatic t_modes();
    for (int m = 1; m < 4; m += 2)
    begin
      start({m[1:0], 6'h0}, 10'd100, 3'd1);
      repeat (4) @(negedge i_clock);
      chk({31'h0, pin_a_oe}, 32'h0, "pin not driven");
      chk({31'h0, pin_b_oe}, 32'h0, "pin b not driven");
      wait_flag(ctm_pkg::EVT_A);
    end
  endtask : t_modes

  // Period 200 stays last; start stops the timer first, so each case counts up from zero
  task automatic t_pwm();
    logic [7:0] c[6] = '{8'hA9, 8'hA1, 8'hAC, 8'h88, 8'h98, 8'hAA};
    int a[6] = '{32, 32, 32, 32, 32, 200};
    int per[6] = '{128, 128, 128, 128, 128, 200};
    int hi[6] = '{32, 96, 96, 0, 128, 128};
    for (int i = 0; i < 6; i++)
    begin
      start(c[i], a[i][9:0], 3'd1);
      repeat (300) @(posedge i_clock);
      load_clr <= 1'b1;
      @(posedge i_clock);
      load_clr <= 1'b0;
      repeat (per[i]) @(posedge i_clock);
      @(negedge i_clock);
      chk(high_cnt, hi[i], "PWM high time");
      rd_chk(ctm_pkg::OFS_STATUS, 32'h3, "PWM flags");
    end
  endtask : t_pwm

  task automatic t_irq();
    start(8'h00, 10'd100, 3'd1);
    wr(ctm_pkg::OFS_INT_EN, 32'h1);
    wait_flag(ctm_pkg::EVT_A);
    repeat (3) @(negedge i_clock);
    chk({31'h0, o_irq}, 32'h1, "irq raised");
    wr(ctm_pkg::OFS_INT_CLR, 32'h1);
    repeat (3) @(negedge i_clock);
    chk({31'h0, o_irq}, 32'h0, "irq cleared");
    wr(ctm_pkg::OFS_INT_EN, 32'h0);
    wait_flag(ctm_pkg::EVT_A);
    chk({31'h0, o_irq}, 32'h0, "irq masked");
  endtask : t_irq

  // Main sequence: reset for 8 cycles, then each scenario in turn
  initial
  begin
    {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, load_clr} = 7'h00;
    i_awaddr = 8'h00;
    i_araddr = 8'h00;
    i_wdata = 32'h0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_regs();
    t_compare();
    t_clear_src();
    t_modes();
    t_pwm();
    t_irq();
    chk(bad_cnt, 0, "pin b complement");
    results();
  end

  // Watchdog well beyond the expected run of about 7000 cycles
  initial
  begin
    #5000000;
    error_cnt++;
    results();
  end
endmodule : tb_compact_timer_mode_output_control
